//--- common/boot_cfg_pkg.sv
// constants and types shared by the boot option and memory size block
package boot_cfg_pkg;
  localparam logic [15:0] OPT_BYTE_ADDR   = 16'h0080; // boot option byte
  localparam logic [15:0] MEM_SIZE_ADDR   = 16'hfff0; // memory size register
  localparam logic [7:0]  MEM_SIZE_RESET  = 8'hcf;
  localparam int          HS_SEL_BIT      = 1;
  localparam int          LOCK_BIT        = 0;
  localparam int          MEM_FIXED0_BIT  = 4;
  localparam int          RAM_MSB         = 7; // ram capacity field
  localparam int          RAM_LSB         = 5;
  localparam int          ROM_MSB         = 3; // rom capacity field
  localparam int          ROM_LSB         = 0;
  localparam logic        OSC_RUN_RESET   = 1'b1;
  localparam logic [7:0]  RDATA_RESET     = 8'h00;
  localparam logic [2:0]  RAM_CODE_768    = 3'h0;
  localparam logic [3:0]  ROM_CODE_8K     = 4'h2;
  localparam logic [3:0]  ROM_CODE_16K    = 4'h4;
  localparam logic        HS_SEL_RESET    = 1'b0;
  localparam logic        LOCK_RESET      = 1'b1; // keep oscillator running

  // settings captured from the option byte
  typedef struct packed {
    logic hs_clock_source_select;
    logic slow_osc_stop_lock;
  } boot_opt_s;

  // loader sequence states
  typedef enum logic [1:0] {
    LD_FETCH,
    LD_WAIT,
    LD_RUN
  } loader_e;
endpackage

//--- logic/boot_option_and_memory_size.sv
// boot option byte loader and memory size select register
// Operation
// - boot option byte is read from flash address 0080h, not a register
// - option bit 1 picks clock: 0 crystal oscillator, 1 internal fast one
// - option bit 0 set locks slow oscillator; software stop then ignored
// - reset loads memory size register with cfh regardless of fitted memory
// - top three bits select ram; only 000 valid, giving 768 bytes
// - low nibble 0010 is 8 KB, 0100 is 16 KB; bit 4 stays zero
module boot_option_and_memory_size (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  output logic             o_flash_rd,
  output logic [15:0]      o_flash_addr,
  input  wire logic [7:0]  i_flash_rdata,
  input  wire logic        i_flash_valid,
  input  wire logic [15:0] i_bus_addr,
  input  wire logic        i_bus_wr,
  input  wire logic        i_bus_rd,
  input  wire logic [7:0]  i_bus_wdata,
  output logic [7:0]       o_bus_rdata,
  input  wire logic        i_slow_osc_stop_req,
  output logic             o_slow_osc_run,
  output logic             o_cpu_run,
  output logic             o_hs_clock_source_select,
  output logic             o_slow_osc_stop_lock,
  output logic [7:0]       o_memory_size_reg,
  output logic             o_ram_size_valid,
  output logic             o_rom_size_valid,
  output logic             o_rom_size_16k
);

  boot_cfg_pkg::loader_e   state_q;
  boot_cfg_pkg::boot_opt_s opt_q;
  logic [7:0]              mem_size_q;
  logic [7:0]              mem_size_d;
  logic                    osc_run_q;
  logic [7:0]              rdata_q;
  logic                    mem_wr;
  logic                    ram_ok_q;
  logic                    rom_ok_q;
  logic                    rom_16k_q;

  // bus address hits the memory size register
  function automatic logic hits_mem_size(input logic [15:0] addr);
    return addr == boot_cfg_pkg::MEM_SIZE_ADDR;
  endfunction

  // ram field holds the one supported capacity code
  function automatic logic ram_code_ok(input logic [7:0] val);
    return val[boot_cfg_pkg::RAM_MSB:boot_cfg_pkg::RAM_LSB] ==
           boot_cfg_pkg::RAM_CODE_768;
  endfunction

  // rom field selects the larger capacity
  function automatic logic rom_code_16k(input logic [7:0] val);
    return val[boot_cfg_pkg::ROM_MSB:boot_cfg_pkg::ROM_LSB] ==
           boot_cfg_pkg::ROM_CODE_16K;
  endfunction

  // rom field holds one of the two supported capacity codes
  function automatic logic rom_code_ok(input logic [7:0] val);
    return rom_code_16k(val) ||
           (val[boot_cfg_pkg::ROM_MSB:boot_cfg_pkg::ROM_LSB] ==
            boot_cfg_pkg::ROM_CODE_8K);
  endfunction

  // loader sequence: fetch once after reset, then release the cpu
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= boot_cfg_pkg::LD_FETCH;
    end else begin
      case (state_q)
        boot_cfg_pkg::LD_FETCH: state_q <= boot_cfg_pkg::LD_WAIT;
        boot_cfg_pkg::LD_WAIT: begin
          if (i_flash_valid) begin
            state_q <= boot_cfg_pkg::LD_RUN;
          end
        end
        default: state_q <= boot_cfg_pkg::LD_RUN;
      endcase
    end
  end

  assign o_flash_rd   = (state_q == boot_cfg_pkg::LD_FETCH);
  assign o_flash_addr = boot_cfg_pkg::OPT_BYTE_ADDR;
  assign o_cpu_run    = (state_q == boot_cfg_pkg::LD_RUN);

  // capture only the two setting bits; upper bits are not looked at
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      opt_q.hs_clock_source_select <= boot_cfg_pkg::HS_SEL_RESET;
      opt_q.slow_osc_stop_lock     <= boot_cfg_pkg::LOCK_RESET;
    end else if (state_q == boot_cfg_pkg::LD_WAIT && i_flash_valid) begin
      opt_q.hs_clock_source_select <= i_flash_rdata[boot_cfg_pkg::HS_SEL_BIT];
      opt_q.slow_osc_stop_lock     <= i_flash_rdata[boot_cfg_pkg::LOCK_BIT];
    end
  end

  assign o_hs_clock_source_select = opt_q.hs_clock_source_select;
  assign o_slow_osc_stop_lock     = opt_q.slow_osc_stop_lock;

  // stop request honoured only when unlocked
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      osc_run_q <= boot_cfg_pkg::OSC_RUN_RESET;
    end else begin
      osc_run_q <= !(i_slow_osc_stop_req && !opt_q.slow_osc_stop_lock);
    end
  end

  assign o_slow_osc_run = osc_run_q;

  assign mem_wr = i_bus_wr && hits_mem_size(i_bus_addr);

  // next register value: whole byte writes, bit 4 forced low
  always_comb begin
    mem_size_d = mem_size_q;
    if (mem_wr) begin
      mem_size_d = i_bus_wdata & ~(8'h01 << boot_cfg_pkg::MEM_FIXED0_BIT);
    end
  end

  // memory size register, loaded by reset or by a full byte write
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mem_size_q <= boot_cfg_pkg::MEM_SIZE_RESET;
    end else begin
      mem_size_q <= mem_size_d;
    end
  end

  // size decodes taken from the next value so they never lag the register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ram_ok_q  <= ram_code_ok(boot_cfg_pkg::MEM_SIZE_RESET);
      rom_ok_q  <= rom_code_ok(boot_cfg_pkg::MEM_SIZE_RESET);
      rom_16k_q <= rom_code_16k(boot_cfg_pkg::MEM_SIZE_RESET);
    end else begin
      ram_ok_q  <= ram_code_ok(mem_size_d);
      rom_ok_q  <= rom_code_ok(mem_size_d);
      rom_16k_q <= rom_code_16k(mem_size_d);
    end
  end

  // register read port; unmapped addresses read zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_q <= boot_cfg_pkg::RDATA_RESET;
    end else if (i_bus_rd) begin
      if (hits_mem_size(i_bus_addr)) begin
        rdata_q <= mem_size_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign o_bus_rdata       = rdata_q;
  assign o_memory_size_reg = mem_size_q;

  // prohibited codes stay in the register and show up as invalid here
  assign o_ram_size_valid  = ram_ok_q;
  assign o_rom_size_valid  = rom_ok_q;
  assign o_rom_size_16k    = rom_16k_q;

  // checks on the loader and registers
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_fetch_address: assert property (
    o_flash_rd |-> o_flash_addr == 16'h0080)
    else $error("option fetch not at fixed address");
  a_fetch_after_rst: assert property (
    $past(i_rst) |-> o_flash_rd && !o_cpu_run)
    else $error("no option fetch right after reset");
  a_hs_sel_capture: assert property (
    state_q == boot_cfg_pkg::LD_WAIT && i_flash_valid
    |=> o_hs_clock_source_select == $past(i_flash_rdata[1]) && o_cpu_run)
    else $error("clock source bit not captured");
  a_lock_capture: assert property (
    state_q == boot_cfg_pkg::LD_WAIT && i_flash_valid
    |=> o_slow_osc_stop_lock == $past(i_flash_rdata[0]))
    else $error("oscillator lock bit not captured");
  a_stop_ignored: assert property (
    o_slow_osc_stop_lock && i_slow_osc_stop_req |=> o_slow_osc_run)
    else $error("locked oscillator was stopped");
  a_stop_honoured: assert property (
    !o_slow_osc_stop_lock && i_slow_osc_stop_req |=> !o_slow_osc_run)
    else $error("unlocked oscillator ignored stop");
  a_settings_hold: assert property (
    o_cpu_run |=> o_cpu_run && $stable(opt_q))
    else $error("boot settings changed after load");
  a_mem_write: assert property (
    mem_wr |=> o_memory_size_reg == ($past(i_bus_wdata) & 8'hef))
    else $error("memory size write not stored");
  a_bit4_zero: assert property (
    o_memory_size_reg[4] == 1'b0)
    else $error("memory size bit 4 not zero");
  a_ram_decode: assert property (
    o_ram_size_valid == (o_memory_size_reg[7:5] == 3'h0))
    else $error("ram size decode wrong");
  a_rom_decode: assert property (
    o_rom_size_valid == (o_memory_size_reg[3:0] inside {4'h2, 4'h4}))
    else $error("rom size decode wrong");
  a_rom_large: assert property (
    o_rom_size_16k == (o_memory_size_reg[3:0] == 4'h4))
    else $error("larger rom capacity decode wrong");
  a_read_back: assert property (
    i_bus_rd && i_bus_addr == 16'hfff0
    |=> o_bus_rdata == $past(o_memory_size_reg))
    else $error("memory size read back wrong");
  a_option_unmapped: assert property (
    i_bus_rd && i_bus_addr != 16'hfff0 |=> o_bus_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_reset_value: assert property (
    @(posedge i_sys_clk) $past(i_rst) && !$past(mem_wr)
    |-> o_memory_size_reg == 8'hcf)
    else $error("memory size reset value wrong");

endmodule

//--- verification/testbench.sv
// self-checking bench for the boot option and memory size block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk, i_rst, i_flash_valid, i_bus_wr, i_bus_rd;
  logic        i_slow_osc_stop_req;
  logic [7:0]  i_flash_rdata, i_bus_wdata;
  logic [15:0] i_bus_addr;
  logic        o_flash_rd, o_slow_osc_run, o_cpu_run, o_hs_clock_source_select;
  logic        o_slow_osc_stop_lock, o_ram_size_valid, o_rom_size_valid;
  logic        o_rom_size_16k;
  logic [15:0] o_flash_addr;
  logic [7:0]  o_bus_rdata, o_memory_size_reg, st;
  int          fails, checks_done, cycles;
  boot_option_and_memory_size uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .o_flash_rd(o_flash_rd), .o_flash_addr(o_flash_addr),
    .i_flash_rdata(i_flash_rdata), .i_flash_valid(i_flash_valid),
    .i_bus_addr(i_bus_addr), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
    .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata),
    .i_slow_osc_stop_req(i_slow_osc_stop_req), .o_slow_osc_run(o_slow_osc_run),
    .o_cpu_run(o_cpu_run), .o_hs_clock_source_select(o_hs_clock_source_select),
    .o_slow_osc_stop_lock(o_slow_osc_stop_lock),
    .o_memory_size_reg(o_memory_size_reg), .o_ram_size_valid(o_ram_size_valid),
    .o_rom_size_valid(o_rom_size_valid), .o_rom_size_16k(o_rom_size_16k));
  // status byte: fetch, run, clock source, lock, osc, ram ok, rom ok, 16k
  assign st = {o_flash_rd, o_cpu_run, o_hs_clock_source_select,
    o_slow_osc_stop_lock, o_slow_osc_run, o_ram_size_valid,
    o_rom_size_valid, o_rom_size_16k};
  // clock at 40 ns period
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  task automatic stop_test();
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // reset, check reset state, then hand in one option byte
  task automatic boot(input logic [7:0] b);
    i_rst <= 1'b1;
    repeat (16) @(posedge i_sys_clk);
    #1;
    chk(o_flash_addr[7:0], 8'h80);
    chk(o_flash_addr[15:8], 8'h00);
    chk(o_memory_size_reg, 8'hcf);
    chk(st, 8'h98);
    @(posedge i_sys_clk) i_rst <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_flash_valid <= 1'b1;
    i_flash_rdata <= b;
    @(posedge i_sys_clk) i_flash_valid <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_bus_wr <= 1'b1;
    i_bus_addr <= a;
    i_bus_wdata <= d;
    @(posedge i_sys_clk) i_bus_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_bus_rd <= 1'b1;
    i_bus_addr <= a;
    @(posedge i_sys_clk) i_bus_rd <= 1'b0;
    #1 chk(o_bus_rdata, exp);
  endtask
  // cycle ceiling against a hang
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    {i_rst, i_flash_valid, i_bus_wr, i_bus_rd, i_slow_osc_stop_req} = 5'h10;
    {i_flash_rdata, i_bus_wdata, i_bus_addr} = 32'h0;
    {fails, checks_done, cycles} = 0;
    // option byte with its upper six bits clear
    boot(8'h02);
    // internal fast source taken, oscillator left unlocked
    chk(st, 8'h68);
    // a late option byte is ignored
    @(posedge i_sys_clk);
    i_flash_valid <= 1'b1;
    i_flash_rdata <= 8'h01;
    @(posedge i_sys_clk) i_flash_valid <= 1'b0;
    #1 chk(st, 8'h68);
    // unlocked oscillator obeys a stop request
    @(posedge i_sys_clk) i_slow_osc_stop_req <= 1'b1;
    @(posedge i_sys_clk) i_slow_osc_stop_req <= 1'b0;
    #1 chk(st, 8'h60);
    wr(16'hfff0, 8'h04);
    chk(st, 8'h6f);
    wr(16'hfff0, 8'h02);
    chk(st, 8'h6e);
    wr(16'hfff0, 8'hff);
    chk(o_memory_size_reg, 8'hef);
    chk(st, 8'h68);
    wr(16'hfff1, 8'h04);
    rd(16'hfff0, 8'hef);
    rd(16'h0080, 8'h00);
    // locked oscillator ignores stop, after a mid-run reset
    @(posedge i_sys_clk);
    boot(8'h01);
    chk(st, 8'h58);
    @(posedge i_sys_clk) i_slow_osc_stop_req <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1 chk(st, 8'h58);
    stop_test();
  end
endmodule
